// [inc/smc_pkg.sv]
// Constants, types and register layout of the sleep-mode clock controller.
// Assumes nothing beyond a SystemVerilog compiler.
package smc_pkg;

  // ********************
  // Sleep modes
  // ********************
  typedef enum logic [2:0] {
    SMC_IDLE = 3'h0,
    SMC_ADC_NR = 3'h1,
    SMC_PWR_DOWN = 3'h2,
    SMC_PWR_SAVE = 3'h3,
    SMC_RSVD4 = 3'h4,
    SMC_RSVD5 = 3'h5,
    SMC_STANDBY = 3'h6,
    SMC_EXT_STANDBY = 3'h7
  } smc_mode_e;

  // Controller states, Gray along the sleep/wake path
  typedef enum logic [1:0] {
    SMC_ST_ACTIVE = 2'h0,
    SMC_ST_SLEEP = 2'h1,
    SMC_ST_WAKE = 2'h3,
    SMC_ST_HALT = 2'h2
  } smc_state_e;

  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic asy;
    logic main_osc;
    logic timer_osc;
  } smc_clk_s;

  // ********************
  // Register map
  // ********************
  localparam int SMC_AW = 4;
  localparam int SMC_DW = 8;
  localparam logic [SMC_AW-1:0] SMC_CTRL_ADDR = 4'h0;
  localparam logic [SMC_AW-1:0] SMC_AUX_ADDR = 4'h1;
  localparam logic [SMC_AW-1:0] SMC_CLK_ADDR = 4'h2;
  localparam logic [SMC_AW-1:0] SMC_STAT_ADDR = 4'h3;
  localparam logic [SMC_DW-1:0] SMC_CTRL_RST = 8'h00;
  localparam logic [SMC_DW-1:0] SMC_AUX_RST = 8'h00;
  // Control register fields
  localparam int SMC_SE_BIT = 0;
  localparam int SMC_SM_LSB = 1;
  localparam int SMC_AS0_BIT = 4;
  localparam int SMC_ADCEN_BIT = 5;
  localparam int SMC_CMPDIS_BIT = 6;
  localparam int SMC_CMPBG_BIT = 7;
  // Auxiliary register fields
  localparam int SMC_JTD_BIT = 0;
  localparam int SMC_WDTEN_BIT = 1;

  // ********************
  // Timing counts
  // ********************
  localparam logic [7:0] SMC_STANDBY_WAKE_CYC = 8'h06;
  localparam logic [7:0] SMC_HALT_CYC = 8'h04;
  localparam logic [7:0] SMC_OSC_STARTUP_CYC = 8'h10;

endpackage

// [hw/smc_mode_decode.sv]
// Decodes a sleep-mode selection into the clock domains kept running.
// Assumes the caller holds the selection steady during sleep.
`timescale 1ns/1ns
module smc_mode_decode
  import smc_pkg::*;
(
  input wire logic [2:0] i_sel,
  input wire logic i_async,
  input wire logic i_crystal,
  input wire logic i_debug_hold,
  output smc_pkg::smc_clk_s o_clk,
  output logic o_valid,
  output logic o_deep,
  output logic o_standby
);
  import smc_pkg::*;

  always_comb
  begin
    o_clk = '0;
    o_valid = 1'b1;
    o_deep = 1'b1;
    o_standby = 1'b0;
    case (smc_mode_e'(i_sel))
      SMC_IDLE:
      begin
        o_clk.io = 1'b1;
        o_clk.adc = 1'b1;
        o_clk.asy = i_async;
        o_clk.timer_osc = i_async;
        o_clk.main_osc = 1'b1;
        o_deep = 1'b0;
      end
      SMC_ADC_NR:
      begin
        o_clk.adc = 1'b1;
        o_clk.asy = i_async;
        o_clk.timer_osc = i_async;
        o_clk.main_osc = 1'b1;
        o_deep = 1'b0;
      end
      SMC_PWR_DOWN: o_clk.main_osc = i_debug_hold;
      SMC_PWR_SAVE:
      begin
        o_clk.asy = i_async;
        o_clk.timer_osc = i_async;
        o_clk.main_osc = i_debug_hold;
      end
      SMC_STANDBY:
      begin
        o_clk.main_osc = 1'b1;
        o_valid = i_crystal;
        o_standby = 1'b1;
      end
      SMC_EXT_STANDBY:
      begin
        o_clk.asy = i_async;
        o_clk.timer_osc = i_async;
        o_clk.main_osc = 1'b1;
        o_valid = i_crystal;
        o_standby = 1'b1;
      end
      default: o_valid = 1'b0;
    endcase
  end

endmodule // smc_mode_decode

// [hw/smc_wake_timer.sv]
// Down counter timing the wake latency and the CPU halt.
// Assumes loads of zero are never issued.
`timescale 1ns/1ns
module smc_wake_timer #(
  parameter int W = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  output logic o_done
);
  import smc_pkg::*;

  logic [W-1:0] cnt;

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt <= '0;
    else if (i_load)
      cnt <= i_count;
    else if (cnt != '0)
      cnt <= cnt - 1'b1;
  end

  assign o_done = (cnt == {{(W-1){1'b0}}, 1'b1});

endmodule // smc_wake_timer

// [hw/smc_top.sv]
// Sleep-mode controller: clock gating, wake sequencing and analog enables.
// Assumes the CPU pulses i_sleep_instr for one cycle per sleep instruction,
// and fuse, pin and TAP inputs arrive asynchronously.
//
// Notes on behaviour
// - Sleep happens only when the enable bit is set and a sleep instruction runs.
// - Mode codes: 000 Idle, 001 ADC noise reduction, 010 power-down, 011 power-save.
// - After wake, CPU stays halted four cycles beyond start-up, then resumes.
// - Code 110 with crystal selected enters Standby.
// - Standby equals power-down but the main oscillator runs.
// - Standby wakes after six clock cycles.
// - Code 111 with crystal enters extended standby, oscillator on, six-cycle wake.
// - Sleep stops CPU and flash; domains kept per mode, deep modes stop I/O and converter.
// - Async clock and timer oscillator need the async select bit, as does timer0 wake in power-save and extended standby.
// - In power-down and standby only edge inputs, level inputs and address match wake.
// - Main clock stays on in light and standby modes; wake sources per mode.
// - An enabled converter stays enabled through every sleep mode.
// - First conversion after converter re-enable is an extended one.
// - Comparator switches off automatically in modes deeper than noise reduction unless on the internal reference.
// - Comparator on internal reference keeps reference on unless software disables.
// - Reference on only while brown-out, comparator or converter needs it.
// - Programmed brown-out fuse keeps the detector on in every mode.
// - An enabled watchdog keeps running in every sleep mode.
// - Input buffers off when I/O and converter clocks both stop.
// - Debug fuse with the boundary port enabled keeps main clock running in power-down and power-save.
// - Disable bit or unprogrammed fuse turns off the boundary port and hold.
// - Enabled boundary port leaves the serial output undriven while not shifting.
`timescale 1ns/1ns
module smc_top
  import smc_pkg::*;
#(
  parameter logic [7:0] OSC_STARTUP_CYC = SMC_OSC_STARTUP_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [SMC_AW-1:0] i_addr,
  input wire logic [SMC_DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [SMC_DW-1:0] o_rdata,
  input wire logic i_sleep_instr,
  input wire logic [3:0] i_edge_ext_irq_inputs,
  input wire logic [3:0] i_level_ext_irq_inputs,
  input wire logic i_twi_match,
  input wire logic i_timer0_irq,
  input wire logic i_spm_ready_irq,
  input wire logic i_adc_irq,
  input wire logic i_io_irq,
  input wire logic i_adc_conv_done,
  input wire logic i_crystal_sel,
  input wire logic i_brownout_enable_fuse,
  input wire logic i_debug_enable_fuse,
  input wire logic i_boundary_port_enable_fuse,
  input wire logic i_tap_shifting,
  input wire logic i_tap_tdo,
  output smc_pkg::smc_clk_s o_clk_en,
  output logic o_cpu_halt,
  output logic o_adc_enable,
  output logic o_adc_extended_conv,
  output logic o_cmp_enable,
  output logic o_bandgap_enable,
  output logic o_bod_enable,
  output logic o_wdt_run,
  output logic o_input_buf_en,
  output logic o_boundary_port_en,
  output logic o_tdo_o,
  output logic o_tdo_oe
);
  import smc_pkg::*;

  localparam int NS = 14;

  // ****************************************
  // Reset release and input synchronisers
  // ****************************************
  logic [1:0] rst_sync;
  logic rst_n;
  logic [NS-1:0] sync_a;
  logic [NS-1:0] sync_b;
  logic [3:0] edge_irq;
  logic [3:0] level_irq;
  logic crystal;
  logic bod_fuse;
  logic dbg_fuse;
  logic jtag_fuse;
  logic tap_shift;
  logic tap_tdo;

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  assign rst_n = rst_sync[1];

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= {i_tap_tdo, i_tap_shifting, i_boundary_port_enable_fuse,
                 i_debug_enable_fuse, i_brownout_enable_fuse, i_crystal_sel,
                 i_level_ext_irq_inputs, i_edge_ext_irq_inputs};
      sync_b <= sync_a;
    end
  end

  assign edge_irq = sync_b[3:0];
  assign level_irq = sync_b[7:4];
  assign crystal = sync_b[8];
  assign bod_fuse = sync_b[9];
  assign dbg_fuse = sync_b[10];
  assign jtag_fuse = sync_b[11];
  assign tap_shift = sync_b[12];
  assign tap_tdo = sync_b[13];

  // ********************
  // Register file
  // ********************
  logic [SMC_DW-1:0] ctrl;
  logic [SMC_DW-1:0] aux;
  logic sleep_en;
  logic [2:0] mode_sel;
  logic async_sel;
  logic adc_en;
  logic cmp_dis;
  logic cmp_bg;
  logic boundary_port_disable_bit;
  logic wdt_en;
  smc_state_e state;
  smc_state_e next_state;

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= SMC_CTRL_RST;
      aux <= SMC_AUX_RST;
    end
    else if (i_wr)
    begin
      if (i_addr == SMC_CTRL_ADDR)
        ctrl <= i_wdata;
      else if (i_addr == SMC_AUX_ADDR)
        aux <= i_wdata;
    end
  end

  assign sleep_en = ctrl[SMC_SE_BIT];
  assign mode_sel = ctrl[SMC_SM_LSB +: 3];
  assign async_sel = ctrl[SMC_AS0_BIT];
  assign adc_en = ctrl[SMC_ADCEN_BIT];
  assign cmp_dis = ctrl[SMC_CMPDIS_BIT];
  assign cmp_bg = ctrl[SMC_CMPBG_BIT];
  assign boundary_port_disable_bit = aux[SMC_JTD_BIT];
  assign wdt_en = aux[SMC_WDTEN_BIT];

  // Unmapped addresses read zero
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      o_rdata <= '0;
    else if (i_rd)
    begin
      if (i_addr == SMC_CTRL_ADDR)
        o_rdata <= ctrl;
      else if (i_addr == SMC_AUX_ADDR)
        o_rdata <= aux;
      else if (i_addr == SMC_CLK_ADDR)
        o_rdata <= {1'b0, o_clk_en};
      else if (i_addr == SMC_STAT_ADDR)
        o_rdata <= {4'h0, o_adc_extended_conv, o_bandgap_enable, state};
      else
        o_rdata <= '0;
    end
    else
      o_rdata <= '0;
  end

  // ********************
  // Mode decode
  // ********************
  logic [2:0] mode_q;
  logic [2:0] dec_sel;
  logic jtag_en;
  smc_clk_s sleep_clk;
  logic mode_valid;
  logic mode_deep;
  logic mode_standby;

  assign jtag_en = jtag_fuse & ~boundary_port_disable_bit;
  // Selection frozen during sleep so software writes cannot regate
  assign dec_sel = (state == SMC_ST_ACTIVE) ? mode_sel : mode_q;

  smc_mode_decode u_decode (
    .i_sel(dec_sel),
    .i_async(async_sel),
    .i_crystal(crystal),
    .i_debug_hold(dbg_fuse & jtag_en),
    .o_clk(sleep_clk),
    .o_valid(mode_valid),
    .o_deep(mode_deep),
    .o_standby(mode_standby)
  );

  // ********************
  // Wake sources
  // ********************
  logic ext_wake;
  logic wake_hit;

  assign ext_wake = (|edge_irq) | (|level_irq);
  always_comb
  begin
    wake_hit = ext_wake | i_twi_match;
    case (smc_mode_e'(mode_q))
      SMC_IDLE: wake_hit = wake_hit | i_timer0_irq | i_spm_ready_irq | i_adc_irq | i_io_irq;
      SMC_ADC_NR: wake_hit = wake_hit | i_timer0_irq | i_spm_ready_irq | i_adc_irq;
      SMC_PWR_SAVE, SMC_EXT_STANDBY: wake_hit = wake_hit | (i_timer0_irq & async_sel);
      default: wake_hit = wake_hit;
    endcase
  end

  // ********************
  // Sleep and wake sequencing
  // ********************
  logic tmr_load;
  logic [7:0] tmr_count;
  logic tmr_done;
  logic [7:0] wake_lat;

  always_comb
  begin
    if (mode_standby)
      wake_lat = SMC_STANDBY_WAKE_CYC;
    else if (mode_deep)
      wake_lat = OSC_STARTUP_CYC;
    else
      wake_lat = 8'h00;
  end

  always_comb
  begin
    next_state = state;
    tmr_load = 1'b0;
    tmr_count = SMC_HALT_CYC;
    case (state)
      SMC_ST_ACTIVE:
        if (i_sleep_instr && sleep_en && mode_valid)
          next_state = SMC_ST_SLEEP;
      SMC_ST_SLEEP:
        if (wake_hit)
        begin
          tmr_load = 1'b1;
          if (wake_lat == 8'h00)
            next_state = SMC_ST_HALT;
          else
          begin
            next_state = SMC_ST_WAKE;
            tmr_count = wake_lat;
          end
        end
      SMC_ST_WAKE:
        if (tmr_done)
        begin
          next_state = SMC_ST_HALT;
          tmr_load = 1'b1;
        end
      SMC_ST_HALT:
        if (tmr_done)
          next_state = SMC_ST_ACTIVE;
      default: next_state = SMC_ST_ACTIVE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      state <= SMC_ST_ACTIVE;
    else
      state <= next_state;
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      mode_q <= 3'h0;
    else if (state == SMC_ST_ACTIVE)
      mode_q <= mode_sel;
  end

  smc_wake_timer #(
    .W(8)
  ) u_timer (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_load(tmr_load),
    .i_count(tmr_count),
    .o_done(tmr_done)
  );

  // ********************
  // Clock and analog enables
  // ********************
  logic adc_en_q;
  logic deep_sleep;

  assign deep_sleep = (state == SMC_ST_SLEEP) & mode_deep;

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      o_clk_en <= '0;
    else if (next_state == SMC_ST_SLEEP)
      o_clk_en <= sleep_clk;
    else if (next_state == SMC_ST_ACTIVE)
      o_clk_en <= '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1, asy: async_sel,
                    main_osc: 1'b1, timer_osc: async_sel};
    else
      o_clk_en <= '{cpu: 1'b0, flash: 1'b0, io: 1'b1, adc: 1'b1, asy: async_sel,
                    main_osc: 1'b1, timer_osc: async_sel};
  end

  assign o_cpu_halt = (state != SMC_ST_ACTIVE);
  assign o_adc_enable = adc_en;
  assign o_cmp_enable = ~cmp_dis & (~deep_sleep | cmp_bg);
  assign o_bod_enable = bod_fuse;
  assign o_bandgap_enable = o_bod_enable | (o_cmp_enable & cmp_bg) | adc_en;
  assign o_wdt_run = wdt_en;
  // Wake pins bypass the buffers through their own synchronisers
  assign o_input_buf_en = o_clk_en.io | o_clk_en.adc;
  assign o_boundary_port_en = jtag_en;

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      adc_en_q <= 1'b0;
    else
      adc_en_q <= adc_en;
  end

  // Re-enable wins over the completion clear
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      o_adc_extended_conv <= 1'b1;
    else if (adc_en & ~adc_en_q)
      o_adc_extended_conv <= 1'b1;
    else if (i_adc_conv_done)
      o_adc_extended_conv <= 1'b0;
  end

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_tdo_o <= 1'b0;
      o_tdo_oe <= 1'b0;
    end
    else
    begin
      o_tdo_o <= tap_tdo;
      o_tdo_oe <= jtag_en & tap_shift;
    end
  end

  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!rst_n);

  property p_entry;
    (state == SMC_ST_ACTIVE && i_sleep_instr && sleep_en && mode_valid) |=> state == SMC_ST_SLEEP;
  endproperty
  a_entry: assert property (p_entry) else $error("sleep not entered");

  property p_no_entry;
    (state == SMC_ST_ACTIVE && !(i_sleep_instr && sleep_en)) |=> state == SMC_ST_ACTIVE;
  endproperty
  a_no_entry: assert property (p_no_entry) else $error("sleep without enable");

  property p_reserved;
    (state == SMC_ST_ACTIVE && !mode_valid) |=> state == SMC_ST_ACTIVE && o_clk_en.cpu;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved mode gated clocks");

  property p_cpu_off;
    state == SMC_ST_SLEEP |-> !o_clk_en.cpu && !o_clk_en.flash && o_cpu_halt;
  endproperty
  a_cpu_off: assert property (p_cpu_off) else $error("cpu clock runs in sleep");

  property p_standby_wake;
    (state == SMC_ST_SLEEP && wake_hit && mode_standby)
      |=> (state == SMC_ST_WAKE)[*6] ##1 state == SMC_ST_HALT;
  endproperty
  a_standby_wake: assert property (p_standby_wake) else $error("standby wake not 6");

  property p_halt4;
    $rose(state == SMC_ST_HALT) |-> (o_cpu_halt)[*4] ##1 state == SMC_ST_ACTIVE;
  endproperty
  a_halt4: assert property (p_halt4) else $error("halt not four cycles");

  property p_cmp_auto_off;
    (deep_sleep && !cmp_bg) |-> !o_cmp_enable;
  endproperty
  a_cmp_auto_off: assert property (p_cmp_auto_off) else $error("comparator on in deep");

  property p_ext_conv;
    $rose(adc_en) |=> o_adc_extended_conv;
  endproperty
  a_ext_conv: assert property (p_ext_conv) else $error("extended conversion missed");

  property p_pd_buffers;
    (state == SMC_ST_SLEEP && mode_q == SMC_PWR_DOWN) |-> !o_input_buf_en;
  endproperty
  a_pd_buffers: assert property (p_pd_buffers) else $error("buffers on in power-down");

  property p_tdo_float;
    !(jtag_en && tap_shift) |=> !o_tdo_oe;
  endproperty
  a_tdo_float: assert property (p_tdo_float) else $error("serial output driven");

  c_standby: cover property (state == SMC_ST_SLEEP && mode_standby ##1 state == SMC_ST_WAKE);
  c_idle_wake: cover property (state == SMC_ST_SLEEP && !mode_deep ##1 state == SMC_ST_HALT);
  c_pd_entry: cover property (state == SMC_ST_SLEEP && mode_q == SMC_PWR_DOWN);

endmodule // smc_top

// [sim/smc_cpu_model.sv]
// Behavioural core and converter facing the sleep controller.
// Assumes one clock shared with the controller.
`timescale 1ns/1ns
module smc_cpu_model (
  input wire logic i_mclk,
  input wire logic i_go,
  input wire logic i_conv,
  input wire logic i_halt,
  input wire smc_pkg::smc_clk_s i_clk_en,
  output logic o_sleep_instr,
  output logic o_conv_done
);
  import smc_pkg::*;

  initial
  begin
    o_sleep_instr = 1'b0;
    o_conv_done = 1'b0;
  end

  // A halted core cannot issue a sleep instruction
  always @(posedge i_mclk)
  begin
    o_sleep_instr <= i_go && !i_halt;
    o_conv_done <= i_conv && i_clk_en.adc;
  end
endmodule // smc_cpu_model

// [sim/smc_top_tb.sv]
// Self-checking bench for the sleep-mode clock controller.
// Assumes the core model shares the controller clock.
`timescale 1ns/1ns
module smc_top_tb;
  import smc_pkg::*;
  localparam logic [7:0] OSC = 8'h02;
  logic i_mclk, i_rst_n, i_wr, i_rd, go, conv, ok, dh;
  logic [6:0] wk;
  logic [3:0] pm;
  logic xtal, bodf, dbgf, bpf, tsh, tdo, sleep_instr, conv_done, halt;
  logic adc_en, ext_conv, cmp_en, bg_en, bod_en, wdt_run, ibuf, bp_en, tdo_o, tdo_oe;
  logic [3:0] i_addr;
  logic [2:0] m, s;
  logic [7:0] i_wdata, o_rdata, rd_d, v, ctl, aux;
  smc_clk_s clk_en;
  int n_mismatch = 0;
  int checks_done = 0;
  int seed = 32'h61ad;
  int n;

  smc_top #(.OSC_STARTUP_CYC(OSC)) dut_u (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep_instr(sleep_instr),
    .i_edge_ext_irq_inputs({4{wk[1]}} & pm), .i_level_ext_irq_inputs({4{wk[2]}} & pm),
    .i_twi_match(wk[0]), .i_timer0_irq(wk[3]), .i_spm_ready_irq(wk[4]),
    .i_adc_irq(wk[5]), .i_io_irq(wk[6]), .i_adc_conv_done(conv_done),
    .i_crystal_sel(xtal), .i_brownout_enable_fuse(bodf),
    .i_debug_enable_fuse(dbgf), .i_boundary_port_enable_fuse(bpf),
    .i_tap_shifting(tsh), .i_tap_tdo(tdo), .o_clk_en(clk_en), .o_cpu_halt(halt),
    .o_adc_enable(adc_en), .o_adc_extended_conv(ext_conv), .o_cmp_enable(cmp_en),
    .o_bandgap_enable(bg_en), .o_bod_enable(bod_en), .o_wdt_run(wdt_run),
    .o_input_buf_en(ibuf), .o_boundary_port_en(bp_en), .o_tdo_o(tdo_o),
    .o_tdo_oe(tdo_oe)
  );

  smc_cpu_model cpu_u (
    .i_mclk(i_mclk), .i_go(go), .i_conv(conv), .i_halt(halt), .i_clk_en(clk_en),
    .o_sleep_instr(sleep_instr), .o_conv_done(conv_done)
  );

  // ********************
  // Helpers
  // ********************
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    rd_d = o_rdata;
  endtask

  task automatic sleep_cmd();
    @(posedge i_mclk);
    go <= 1'b1;
    @(posedge i_mclk);
    go <= 1'b0;
    settle(3);
  endtask

  // Gating while asleep; code 4 stands for any code that gates nothing
  function automatic logic [6:0] exp_clk(input logic [2:0] md, input logic a, input logic d);
    case (md)
      3'h0: return {4'h3, a, 1'b1, a};
      3'h1: return {4'h1, a, 1'b1, a};
      3'h2: return {5'h00, d, 1'b0};
      3'h3: return {4'h0, a, d, a};
      3'h6: return 7'h02;
      3'h7: return {4'h0, a, 1'b1, a};
      default: return {4'hF, a, 1'b1, a};
    endcase
  endfunction

  function automatic logic [7:0] lat(input logic [2:0] md);
    if (md < 3'h2)
      return 8'h05;
    if (md < 3'h4)
      return OSC + 8'h05;
    return 8'h0B;
  endfunction

  // Sources: 0 match, 1 edge pin, 2 level pin, 3 timer0, 4 store ready, 5 converter, 6 I/O
  function automatic logic wakes(input logic [2:0] md, input logic a, input logic [2:0] src);
    case (src)
      3'h3: return md < 3'h2 || (a && (md == 3'h3 || md == 3'h7));
      3'h4, 3'h5: return md < 3'h2;
      3'h6: return md == 3'h0;
      default: return 1'b1;
    endcase
  endfunction

  initial
  begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  // ********************
  // Main sequence
  // ********************
  initial
  begin
    {i_rst_n, i_wr, i_rd, go, conv, xtal, bodf, dbgf, bpf, tsh, tdo} = '0;
    {i_addr, i_wdata, wk, pm} = '0;
    settle(3);
    chk("clk_rst", clk_en, 8'h00);
    chk("ext_rst", ext_conv, 8'h01);
    i_rst_n <= 1'b1;
    settle(5);
    chk("clk_run", clk_en, 8'h7A);
    v = 8'($random(seed)) & 8'hFE;
    wr(SMC_CTRL_ADDR, v);
    wr(SMC_STAT_ADDR, 8'hFF);
    rd(SMC_CTRL_ADDR);
    chk("ctrl", rd_d, v);
    rd(4'hF);
    chk("unmapped", rd_d, 8'h00);
    rd(SMC_STAT_ADDR);
    chk("stat", rd_d & 8'h0B, 8'h08);
    sleep_cmd();
    chk("no_se", halt, 8'h00);
    // Converter re-enable forces an extended conversion
    wr(SMC_CTRL_ADDR, 8'h20);
    @(posedge i_mclk);
    conv <= 1'b1;
    @(posedge i_mclk);
    conv <= 1'b0;
    settle(3);
    chk("ext_clr", ext_conv, 8'h00);
    wr(SMC_CTRL_ADDR, 8'h00);
    wr(SMC_CTRL_ADDR, 8'h20);
    settle(2);
    chk("ext_set", ext_conv, 8'h01);
    bpf <= 1'b1;
    settle(5);
    chk("bp_on", {bp_en, tdo_oe}, 8'h02);
    tsh <= 1'b1;
    tdo <= 1'b1;
    settle(5);
    chk("tdo", {tdo_oe, tdo_o}, 8'h03);
    wr(SMC_AUX_ADDR, 8'h01);
    settle(2);
    chk("bp_off", bp_en, 8'h00);
    tsh <= 1'b0;
    for (int it = 0; it < 32; it++)
    begin
      m = (it < 16) ? it[2:0] : 3'($random(seed));
      xtal <= (it < 16) ? it[3] : 1'($random(seed));
      {bodf, dbgf, bpf} <= 3'($random(seed));
      pm <= 4'h1 << 2'($random(seed));
      aux = 8'($random(seed)) & 8'h03;
      ctl = {4'($random(seed)), m, 1'b1};
      wr(SMC_AUX_ADDR, aux);
      wr(SMC_CTRL_ADDR, ctl);
      sleep_cmd();
      ok = m < 3'h4 || (m > 3'h5 && xtal);
      dh = dbgf & bpf & !aux[0];
      chk("clk", clk_en, exp_clk(ok ? m : 3'h4, ctl[4], dh));
      chk("halt", halt, ok);
      chk("cmp", cmp_en, !ctl[6] && (m < 3'h2 || !ok || ctl[7]));
      chk("bg", bg_en, bodf | ctl[5] | (ctl[7] & !ctl[6]));
      chk("ibuf", ibuf, !ok || m < 3'h2);
      chk("misc", {bod_en, wdt_run, adc_en}, {bodf, aux[1], ctl[5]});
      if (ok)
      begin
        rd(SMC_STAT_ADDR);
        chk("state", rd_d & 8'h03, 8'h01);
        if (m != 3'h0)
        begin
          wk <= 7'h40;
          settle(4);
          chk("io_wake", halt, 8'h01);
          wk <= 7'h00;
        end
        // Refused source must leave the core halted; the address match then wakes it
        s = 3'($random(seed)) % 3'h7;
        if (!wakes(m, ctl[4], s))
        begin
          @(posedge i_mclk);
          wk <= 7'h01 << s;
          settle(4);
          chk("src_wake", halt, 8'h01);
          wk <= 7'h00;
          s = 3'h0;
        end
        @(posedge i_mclk);
        wk <= 7'h01 << s;
        for (n = 1; n < 40; n++)
        begin
          settle(1);
          if (n == 1)
            chk("cpu_off", clk_en.cpu, 8'h00);
          if (halt === 1'b0)
            break;
        end
        wk <= 7'h00;
        // Pin sources pass the two-flop synchroniser first
        chk("wake", 8'(n), lat(m) + ((s == 3'h1 || s == 3'h2) ? 8'h02 : 8'h00));
        if (n == 40)
          break;
      end
      wr(SMC_CTRL_ADDR, 8'h00);
      settle(2);
      chk("clk_back", clk_en, exp_clk(3'h4, 1'b0, dh));
    end
    final_report();
  end
endmodule // smc_top_tb
